// ==== logic/hssi_pkg.sv ====
// Constants and types for the homing sequencer of one servo axis.
// Assumes one 10 MHz clock and a synchronous active-high reset.
// What this block does
// RQ1 - Methods 23-26: home switch, positive limit
// RQ2 - Methods 27-30: home switch, negative limit
// RQ3 - 23 low start: forward first, reverse second
// RQ4 - 23 high start: reverse second, zero at fall
// RQ5 - 23 after limit: first speed, then second
// RQ6 - 24 low start: forward first, zero at rise
// RQ7 - 24 high start: reverse, turn at fall
// RQ8 - 24 after limit: keep first, turn at fall
// RQ9 - 25: forward, reverse at fall, zero at rise
// RQ10 - 26: forward, second after rise, zero fall
// RQ11 - 26 after limit: turn at rise, zero fall
// RQ12 - Limit high, home low: reverse direction
// RQ13 - 27: reverse first, turn at rise, zero fall
// RQ14 - 28: reverse first, zero at rise
// RQ15 - 29 high start: reverse, turn at fall
// RQ16 - 30 after limit: turn at rise, zero fall
// RQ17 - Codes 31 and 32 start nothing
// RQ18 - 33: reverse second, zero at index
// RQ19 - 34: forward second, zero at index
// RQ20 - 35: no motion, zero at once
// RQ21 - Synchronise inputs before edge detection
// RQ22 - On zero: stop, load zero, signal done

package hssi_pkg;

  // ----------------------------------------
  // Method codes
  // ----------------------------------------
  typedef logic [7:0] hssi_meth_t;
  localparam hssi_meth_t HSSI_M_SW_LO = 8'h17; // First switch method (23)
  localparam hssi_meth_t HSSI_M_SW_HI = 8'h1E; // Last switch method (30)
  localparam hssi_meth_t HSSI_M_RSV_A = 8'h1F; // Reserved (31)
  localparam hssi_meth_t HSSI_M_RSV_B = 8'h20; // Reserved (32)
  localparam hssi_meth_t HSSI_M_IDX_R = 8'h21; // Index, reverse (33)
  localparam hssi_meth_t HSSI_M_IDX_F = 8'h22; // Index, forward (34)
  localparam hssi_meth_t HSSI_M_HERE = 8'h23; // Current position (35)
  localparam hssi_meth_t HSSI_M_NEG = 8'h1B; // First negative-side method (27)
  localparam hssi_meth_t HSSI_M_24 = 8'h18; // Seek-rise method, positive side

  // ----------------------------------------
  // Switch method families, offset from the first switch method
  // ----------------------------------------
  typedef enum logic [1:0] {
    HSSI_K_REVFALL = 2'b00, // 23/27: turn away at rise, zero at fall
    HSSI_K_SEEKRISE = 2'b01, // 24/28: zero at rise when heading in
    HSSI_K_OVERRISE = 2'b10, // 25/29: zero at rise when heading out
    HSSI_K_PASSFALL = 2'b11 // 26/30: head in at rise, zero at fall
  } hssi_kind_t;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    HSSI_IDLE = 2'b00, // No motion commanded
    HSSI_TRACK = 2'b01, // Following the home switch
    HSSI_INDEX = 2'b10 // Waiting for the first index pulse
  } hssi_state_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  localparam int unsigned HSSI_NSW = 4; // Number of sensed inputs
  typedef struct packed {
    logic home; // Home switch level
    logic lim_pos; // Positive travel limit level
    logic lim_neg; // Negative travel limit level
    logic index; // Encoder index pulse
  } hssi_sw_t;

  typedef struct packed {
    logic move; // Motion commanded
    logic fwd; // Direction, high is forward
    logic second; // High selects second speed
  } hssi_cmd_t;

  localparam hssi_cmd_t HSSI_CMD_RST = 3'h0; // Idle command after reset
  localparam logic [HSSI_NSW-1:0] HSSI_SW_RST = 4'h0; // Synchroniser reset

endpackage : hssi_pkg

// ==== logic/hssi_seq.sv ====
// Homing sequencer: switch methods 23-30, index methods 33-34, method 35.
// Assumes switch and index levels are raw pins; the trajectory generator
// follows cmd_ff and the position counter loads zero on zero_load_ff.
`timescale 1ns/1ps

module hssi_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Homing request
  input wire hssi_pkg::hssi_meth_t method,
  input wire logic start,
  input wire logic abort_req,
  // Sensors
  input wire hssi_pkg::hssi_sw_t sw_in,
  // Motion command
  output hssi_pkg::hssi_cmd_t cmd_ff,
  // Position counter and status
  output logic zero_load_ff,
  output logic done_ff,
  output logic busy_ff,
  output logic reject_ff
);
  import hssi_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [HSSI_NSW-1:0] s1_ff; // First stage, read only by s2
  logic [HSSI_NSW-1:0] s2_ff; // Stable level
  logic [HSSI_NSW-1:0] s3_ff; // Previous stable level
  logic [HSSI_NSW-1:0] raw_v; // Sensor pins as a vector
  logic [HSSI_NSW-1:0] rise_v; // One-cycle rising edges
  logic [HSSI_NSW-1:0] fall_v; // One-cycle falling edges
  hssi_sw_t lvl; // Synchronised levels
  hssi_sw_t rise; // Rising edges by name
  hssi_sw_t fall; // Falling edges by name

  assign raw_v = sw_in;

  // Two flops per input, then a third for edge detection
  genvar gi;
  generate
    for (gi = 0; gi < HSSI_NSW; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          s1_ff[gi] <= HSSI_SW_RST[gi];
          s2_ff[gi] <= HSSI_SW_RST[gi];
          s3_ff[gi] <= HSSI_SW_RST[gi];
        end else begin
          s1_ff[gi] <= raw_v[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi]; // RQ21
        end
      end
    end
  endgenerate

  // Edges come from the stable stages only, so each change shows once
  assign rise_v = s2_ff & ~s3_ff; // RQ21
  assign fall_v = ~s2_ff & s3_ff; // RQ21
  assign lvl = s2_ff;
  assign rise = rise_v;
  assign fall = fall_v;

  // ----------------------------------------
  // Method decode
  // ----------------------------------------
  hssi_meth_t moff; // Offset inside the switch methods
  logic is_sw; // Request names a switch method
  hssi_kind_t req_kind; // Family of the requested method
  logic req_mirror; // Negative-limit side

  assign moff = method - HSSI_M_SW_LO;
  assign is_sw = (method >= HSSI_M_SW_LO) && (method <= HSSI_M_SW_HI);
  assign req_kind = hssi_kind_t'(moff[1:0]);
  assign req_mirror = (method >= HSSI_M_NEG); // RQ2

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  hssi_state_t state_ff; // Current phase
  hssi_state_t nxt_state;
  hssi_kind_t kind_ff; // Latched family
  hssi_kind_t nxt_kind;
  logic mirror_ff; // Latched side, high is negative limit
  logic nxt_mirror;
  logic toward_ff; // Heading toward the side limit
  logic nxt_toward;
  logic second_ff; // Second speed selected
  logic nxt_second;
  logic hit; // Zero point reached this cycle
  logic bad; // Request refused
  logic take; // Start seen while idle this cycle, refused or not
  logic lim; // Limit on the working side

  assign take = start && (state_ff == HSSI_IDLE);
  assign lim = mirror_ff ? lvl.lim_neg : lvl.lim_pos;

  // Next-state logic. Direction is kept as "toward the limit" so that
  // the negative-side methods reuse the positive-side walk mirrored.
  always_comb begin
    nxt_state = state_ff;
    nxt_kind = kind_ff;
    nxt_mirror = mirror_ff;
    nxt_toward = toward_ff;
    nxt_second = second_ff;
    hit = 1'b0;
    bad = 1'b0;
    unique case (state_ff)
      HSSI_IDLE: begin
        if (start) begin
          if (is_sw) begin // RQ1 RQ2
            nxt_state = HSSI_TRACK;
            nxt_kind = req_kind;
            nxt_mirror = req_mirror;
            if (lvl.home) begin
              // Switch already high: start at second speed
              nxt_second = 1'b1; // RQ4 RQ7 RQ9 RQ10 RQ13 RQ15
              nxt_toward = (req_kind == HSSI_K_OVERRISE) ||
                           (req_kind == HSSI_K_PASSFALL);
            end else begin
              // Switch low: head for the limit at first speed
              nxt_second = 1'b0; // RQ3 RQ6 RQ9 RQ10 RQ13 RQ14
              nxt_toward = 1'b1;
            end
          end else if (method == HSSI_M_IDX_R) begin
            // Reverse at second speed to the first index
            nxt_state = HSSI_INDEX; // RQ18
            nxt_mirror = 1'b0;
            nxt_toward = 1'b0;
            nxt_second = 1'b1;
          end else if (method == HSSI_M_IDX_F) begin
            // Forward at second speed to the first index
            nxt_state = HSSI_INDEX; // RQ19
            nxt_mirror = 1'b0;
            nxt_toward = 1'b1;
            nxt_second = 1'b1;
          end else if (method == HSSI_M_HERE) begin
            hit = 1'b1; // RQ20
          end else begin
            // Reserved and unknown codes never move the axis
            bad = 1'b1; // RQ17
          end
        end
      end
      HSSI_TRACK: begin
        if (rise.home) begin
          unique case (kind_ff)
            HSSI_K_REVFALL: begin
              // Leave the switch outward at second speed
              nxt_toward = 1'b0; // RQ3 RQ5 RQ13
              nxt_second = 1'b1;
            end
            HSSI_K_SEEKRISE: begin
              // Only the inward edge is the zero; outward keeps speed
              hit = toward_ff; // RQ6 RQ7 RQ8 RQ14
            end
            HSSI_K_OVERRISE: begin
              hit = !toward_ff; // RQ9 RQ15
              nxt_second = 1'b1;
            end
            HSSI_K_PASSFALL: begin
              // Cross the switch inward at second speed
              nxt_toward = 1'b1; // RQ10 RQ11 RQ16
              nxt_second = 1'b1;
            end
          endcase
        end else if (fall.home) begin
          unique case (kind_ff)
            HSSI_K_REVFALL: hit = 1'b1; // RQ3 RQ4 RQ5 RQ13
            HSSI_K_PASSFALL: hit = 1'b1; // RQ10 RQ11 RQ16
            HSSI_K_SEEKRISE: begin
              // Turn back inward and approach at second speed
              nxt_toward = 1'b1; // RQ7 RQ8 RQ14
              nxt_second = 1'b1;
            end
            HSSI_K_OVERRISE: begin
              // Overshot: turn outward and take the next rise
              nxt_toward = 1'b0; // RQ9 RQ15
              nxt_second = 1'b1;
            end
          endcase
        end else if (toward_ff && lim && !lvl.home) begin
          // Limit reached before the switch: turn back, first speed
          nxt_toward = 1'b0; // RQ12
          nxt_second = 1'b0; // RQ5 RQ8
        end
      end
      HSSI_INDEX: begin
        hit = rise.index; // RQ18 RQ19
      end
      default: begin
        nxt_state = HSSI_IDLE;
      end
    endcase
    // Zero capture or abort ends the move at once
    if (hit || abort_req) begin
      nxt_state = HSSI_IDLE; // RQ22
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= HSSI_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Motion context
  always_ff @(posedge clk) begin
    if (rst) begin
      kind_ff <= HSSI_K_REVFALL;
      mirror_ff <= 1'b0;
      toward_ff <= 1'b0;
      second_ff <= 1'b0;
    end else begin
      kind_ff <= nxt_kind;
      mirror_ff <= nxt_mirror;
      toward_ff <= nxt_toward;
      second_ff <= nxt_second;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Command follows the next state so it changes with the decision edge
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_ff <= HSSI_CMD_RST;
    end else begin
      cmd_ff.move <= (nxt_state != HSSI_IDLE); // RQ20 RQ22
      cmd_ff.fwd <= nxt_toward ^ nxt_mirror;
      cmd_ff.second <= nxt_second;
    end
  end

  // Zero load is a one-cycle pulse at the capture edge
  always_ff @(posedge clk) begin
    if (rst) begin
      zero_load_ff <= 1'b0;
    end else begin
      zero_load_ff <= hit; // RQ22
    end
  end

  // Done stays until the next start seen while idle, refused or not; a set wins a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      done_ff <= 1'b0;
    end else if (hit) begin
      done_ff <= 1'b1; // RQ22
    end else if (take) begin
      done_ff <= 1'b0;
    end
  end

  // Busy mirrors the moving phases
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_ff <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != HSSI_IDLE);
    end
  end

  // Refusal flag, cleared by the next accepted request
  always_ff @(posedge clk) begin
    if (rst) begin
      reject_ff <= 1'b0;
    end else if (bad) begin
      reject_ff <= 1'b1; // RQ17
    end else if (take) begin
      reject_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_take(hssi_meth_t m);
    take && (method == m);
  endsequence

  sequence s_move(logic f, logic sp);
    cmd_ff.move && (cmd_ff.fwd == f) && (cmd_ff.second == sp);
  endsequence

  a_zero_stops: assert property ( // RQ22
    zero_load_ff |-> !cmd_ff.move && done_ff && !busy_ff ##1 !zero_load_ff)
    else $error("zero load without stop and done");

  a_reserved_idle: assert property ( // RQ17
    take && ((method == HSSI_M_RSV_A) || (method == HSSI_M_RSV_B)) |=>
      reject_ff && !cmd_ff.move && !busy_ff && !zero_load_ff)
    else $error("reserved method moved or was not refused");

  a_here_zero: assert property ( // RQ20
    s_take(HSSI_M_HERE) |=> zero_load_ff && done_ff && !cmd_ff.move)
    else $error("method 35 did not zero in place");

  a_index_reverse: assert property ( // RQ18
    s_take(HSSI_M_IDX_R) ##0 !abort_req |=> s_move(1'b0, 1'b1))
    else $error("method 33 wrong command");

  a_index_forward: assert property ( // RQ19
    s_take(HSSI_M_IDX_F) ##0 !abort_req |=> s_move(1'b1, 1'b1))
    else $error("method 34 wrong command");

  a_index_capture: assert property ( // RQ18
    (state_ff == HSSI_INDEX) && rise.index |=> zero_load_ff ##1 !zero_load_ff)
    else $error("index pulse not captured");

  a_pos_low_start: assert property ( // RQ3
    s_take(HSSI_M_SW_LO) ##0 (!lvl.home && !abort_req) |=> s_move(1'b1, 1'b0))
    else $error("method 23 low start wrong");

  a_pos_high_start: assert property ( // RQ4
    s_take(HSSI_M_SW_LO) ##0 (lvl.home && !abort_req) |=> s_move(1'b0, 1'b1))
    else $error("method 23 high start wrong");

  a_seek_rise_zero: assert property ( // RQ6
    (state_ff == HSSI_TRACK) && (kind_ff == HSSI_K_SEEKRISE) && toward_ff &&
      rise.home |=> zero_load_ff)
    else $error("method 24 did not zero at rise");

  a_neg_low_start: assert property ( // RQ2
    s_take(HSSI_M_NEG) ##0 (!lvl.home && !abort_req) |=> s_move(1'b0, 1'b0))
    else $error("method 27 low start wrong");

  a_limit_turn: assert property ( // RQ12
    (state_ff == HSSI_TRACK) && toward_ff && lim && !lvl.home && !rise.home &&
      !fall.home && !abort_req |=> !toward_ff && !cmd_ff.second && cmd_ff.move)
    else $error("limit did not reverse motion");

  a_edge_single: assert property ( // RQ21
    (rise_v & $past(rise_v)) == 4'h0)
    else $error("edge seen twice");

endmodule : hssi_seq

// ==== tb/hssi_axis_model.sv ====
// Axis model: trajectory follower with home cam, travel limits and index.
// Assumes it follows the sequencer command and zero load ports directly.
`timescale 1ns/1ps

module hssi_axis_model
  import hssi_pkg::*;
(
  // Clock
  input wire logic clk,
  // From the sequencer
  input wire hssi_pkg::hssi_cmd_t cmd,
  input wire logic zero_load,
  // Sensor levels
  output hssi_pkg::hssi_sw_t sw
);
  // ----------------------------------------
  // Geometry, in position steps
  // ----------------------------------------
  localparam int HOME_LO = 40; // Home cam lower end
  localparam int HOME_HI = 59; // Home cam upper end
  localparam int LIM_POS = 100; // Positive limit from here up
  localparam int LIM_NEG = 0; // Negative limit from here down
  int pos = 0; // Axis position
  int zero_at = 0; // Position held when zero was loaded
  int tick = 0; // Step divider

  // Second speed is slow so that the sync delay stays under one step
  // Non-blocking so the sequencer never races the sensor update
  always @(posedge clk) begin
    if (zero_load) begin
      zero_at <= pos;
      pos <= 0;
    end else if (cmd.move) begin
      if (tick + 1 >= (cmd.second ? 8 : 2)) begin
        tick <= 0;
        pos <= pos + (cmd.fwd ? 1 : -1);
      end else begin
        tick <= tick + 1;
      end
    end
  end

  // Sensor levels follow the position; index repeats every 16 steps
  assign sw = {(pos >= HOME_LO) && (pos <= HOME_HI), pos >= LIM_POS, pos <= LIM_NEG,
               (pos & 15) == 5};

  // Places the axis before a run
  task set_pos(input int p);
    pos = p;
    tick = 0;
  endtask : set_pos
endmodule : hssi_axis_model

// ==== tb/hssi_seq_bench.sv ====
// Self-checking bench for the homing sequencer with the axis model.
// Assumes the design's package is compiled first.
`timescale 1ns/1ps

module hssi_seq_bench;
  import hssi_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  localparam int MAX_CYC = 60000; // Hang ceiling, runs need far fewer
  logic clk = 1'b0;
  logic rst = 1'b1;
  hssi_meth_t method = 8'h00;
  logic start = 1'b0;
  logic abort_req = 1'b0;
  hssi_sw_t sw_in;
  hssi_cmd_t cmd_ff;
  logic zero_load_ff;
  logic done_ff;
  logic busy_ff;
  logic reject_ff;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  // 100 ns clock
  always #50 clk = ~clk;

  hssi_seq hssi_seq_i (.clk(clk), .rst(rst), .method(method), .start(start),
    .abort_req(abort_req), .sw_in(sw_in), .cmd_ff(cmd_ff), .zero_load_ff(zero_load_ff),
    .done_ff(done_ff), .busy_ff(busy_ff), .reject_ff(reject_ff));
  hssi_axis_model hssi_axis_model_i (.clk(clk), .cmd(cmd_ff), .zero_load(zero_load_ff),
    .sw(sw_in));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task report_and_stop;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles >= MAX_CYC) begin
      errors++;
      report_and_stop();
    end
  end

  task wait_cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_cyc

  // One-cycle trigger, driven at the falling edge
  task pulse_start(input hssi_meth_t m);
    method = m;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask : pulse_start

  // One homing run: trail of distinct commands, packed a nibble each
  task run_home(input hssi_meth_t m, input int p0, input logic [15:0] exp_trail,
                input int exp_zero);
    logic [15:0] trail;
    hssi_cmd_t last;
    int n;
    logic near;
    hssi_axis_model_i.set_pos(p0);
    // Synchronisers need a few edges to see the new levels
    wait_cyc(6);
    pulse_start(m);
    n = 0;
    while (busy_ff !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    check("busy_rise", busy_ff, 1'b1);
    check("done_clear", done_ff, 1'b0);
    check("reject_clear", reject_ff, 1'b0);
    trail = {12'h000, 1'b0, cmd_ff};
    last = cmd_ff;
    n = 0;
    while (busy_ff === 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
      if (cmd_ff !== last) begin
        // Direction and speed keep stale values once motion stops; log idle as zero
        trail = {trail[11:0], 1'b0, cmd_ff.move ? cmd_ff : HSSI_CMD_RST};
        last = cmd_ff;
      end
    end
    check("cmd_trail", trail, exp_trail);
    check("zero_pulse", zero_load_ff, 1'b1);
    @(negedge clk);
    check("zero_one_cycle", zero_load_ff, 1'b0);
    check("done_set", done_ff, 1'b1);
    // Sync delay may carry the axis a few steps past the edge
    near = (hssi_axis_model_i.zero_at >= exp_zero - 3) &&
           (hssi_axis_model_i.zero_at <= exp_zero + 3);
    check("zero_pos", near, 1'b1);
  endtask : run_home

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Starts: 10 below cam, 50 on cam, 70 between cam and limit
  task t_pos_side;
    run_home(8'h17, 10, 16'h0650, 39);
    run_home(8'h17, 50, 16'h0050, 39);
    run_home(8'h17, 70, 16'h6450, 39);
    run_home(8'h18, 10, 16'h0060, 40);
    run_home(8'h18, 50, 16'h0570, 40);
    run_home(8'h18, 70, 16'h6470, 40);
    run_home(8'h19, 10, 16'h6750, 59);
    run_home(8'h19, 50, 16'h0750, 59);
    run_home(8'h19, 70, 16'h0640, 59);
    run_home(8'h1A, 10, 16'h0670, 60);
    run_home(8'h1A, 50, 16'h0070, 60);
    run_home(8'h1A, 70, 16'h6470, 60);
  endtask : t_pos_side

  // Starts: 90 above cam, 50 on cam, 20 between limit and cam
  task t_neg_side;
    run_home(8'h1B, 90, 16'h0470, 60);
    run_home(8'h1B, 50, 16'h0070, 60);
    run_home(8'h1B, 20, 16'h4670, 60);
    run_home(8'h1C, 90, 16'h0040, 59);
    run_home(8'h1C, 50, 16'h0750, 59);
    run_home(8'h1C, 20, 16'h4650, 59);
    run_home(8'h1D, 90, 16'h4570, 40);
    run_home(8'h1D, 50, 16'h0570, 40);
    run_home(8'h1D, 20, 16'h0460, 40);
    run_home(8'h1E, 90, 16'h0450, 39);
    run_home(8'h1E, 50, 16'h0050, 39);
    run_home(8'h1E, 20, 16'h4650, 39);
  endtask : t_neg_side

  task t_index;
    run_home(8'h21, 50, 16'h0050, 37);
    run_home(8'h22, 50, 16'h0070, 53);
  endtask : t_index

  // Present position becomes zero without any motion
  task t_here;
    int n;
    logic moved;
    hssi_axis_model_i.set_pos(77);
    wait_cyc(6);
    pulse_start(8'h23);
    n = 0;
    moved = busy_ff;
    while (zero_load_ff !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
      moved = moved | busy_ff;
    end
    check("here_zero", zero_load_ff, 1'b1);
    check("here_done", done_ff, 1'b1);
    check("here_still", moved | cmd_ff.move, 1'b0);
    @(negedge clk);
    check("here_pos", hssi_axis_model_i.zero_at == 77, 1'b1);
  endtask : t_here

  // Reserved and unknown codes start nothing
  task t_reserved;
    hssi_meth_t codes [4] = '{8'h1F, 8'h20, 8'h16, 8'h24};
    for (int i = 0; i < 4; i++) begin
      pulse_start(codes[i]);
      wait_cyc(3);
      check("reject", {reject_ff, busy_ff, cmd_ff}, 16'h0010);
      // An accepted start clears the flag, so each code is judged afresh
      pulse_start(8'h23);
      wait_cyc(2);
      check("reject_cleared", {reject_ff, busy_ff}, 16'h0000);
    end
  endtask : t_reserved

  // Start while busy is ignored; abort stops without a zero load
  task t_abort;
    hssi_axis_model_i.set_pos(10);
    wait_cyc(6);
    pulse_start(8'h17);
    wait_cyc(10);
    pulse_start(8'h23);
    wait_cyc(3);
    check("busy_ignore", {busy_ff, done_ff, zero_load_ff}, 16'h0004);
    abort_req = 1'b1;
    @(negedge clk);
    abort_req = 1'b0;
    wait_cyc(3);
    // Direction and speed hold stale values at rest, so only motion is judged
    check("abort_idle", {busy_ff, done_ff, zero_load_ff, cmd_ff.move}, 16'h0000);
  endtask : t_abort

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    wait_cyc(2);
    t_reserved();
    t_here();
    t_pos_side();
    t_neg_side();
    t_index();
    t_abort();
    report_and_stop();
  end
endmodule : hssi_seq_bench
